// ### dv/rfs_host_model.sv
// Host side of the reset and good lines, both open-drain with pull-ups.
// Assumes the supervisor's outputs are the pull-down controls.
module rfs_host_model (
   input  wire logic    clk_sys_i,
   input  wire logic    reset_drv_n_i,
   input  wire logic    good_drv_i,
   output logic         reset_pin_n_o,
   output logic         good_pin_o,
   output int unsigned  releases_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_n_r;
   // Released line floats to the pull-up; unknown drive stays unknown
   assign reset_pin_n_o = reset_drv_n_i ? 1'h1 : 1'h0;
   assign good_pin_o    = good_drv_i ? 1'h1 : 1'h0;
   initial releases_o = 0;
   always @(posedge clk_sys_i) begin
      last_n_r <= reset_pin_n_o;
      if (reset_pin_n_o === 1'h1 && last_n_r === 1'h0)
         releases_o <= releases_o + 1;
   end
endmodule

// ### dv/rfs_supervisor_monitor.sv
// Concurrent checks on the supervisor's top-level ports.
// Assumes one clock domain with synchronous active-high reset.
module rfs_supervisor_monitor #(
   parameter int unsigned RESET_DELAY_CYC = 20,
   parameter int unsigned OV_DELAY_CYC    = 10
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic logic_enable_input_i,
   input wire logic battery_enable_one_i,
   input wire logic battery_enable_two_i,
   input wire logic io_rail_uv_i,
   input wire logic core_rail_uv_i,
   input wire logic aux_rail_uv_i,
   input wire logic prot_rail_uv_i,
   input wire logic io_rail_ov_i,
   input wire logic core_rail_ov_i,
   input wire logic aux_rail_ov_i,
   input wire logic prot_rail_ov_i,
   input wire logic prot_rail_batt_short_i,
   input wire logic thermal_shutdown_flag_i,
   input wire logic catch_diode_missing_i,
   input wire logic core_hs_over_limit_i,
   input wire logic pre_regulator_output_ov_i,
   input wire logic rail_reset_out_n_o,
   input wire logic five_volt_good_out_o,
   input wire logic master_fault_reset_o,
   input wire logic regulators_off_o,
   input wire logic pre_switch_enable_o,
   input wire logic core_pulse_end_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned ok_cnt_r;
   int unsigned ov_cnt_r;
   int unsigned aux_cnt_r;
   wire logic   en_any;
   wire logic   ov_io;
   wire logic   ov_aux;
   assign en_any = logic_enable_input_i | battery_enable_one_i
                   | battery_enable_two_i;
   assign ov_io  = io_rail_ov_i | core_rail_ov_i;
   assign ov_aux = aux_rail_ov_i | prot_rail_ov_i;
   // Run lengths of each qualifying condition
   always_ff @(posedge clk_sys_i) begin
      ok_cnt_r  <= (rst_i | io_rail_uv_i | core_rail_uv_i) ? 0 : ok_cnt_r + 1;
      ov_cnt_r  <= (rst_i | !ov_io) ? 0 : ov_cnt_r + 1;
      aux_cnt_r <= (rst_i | !ov_aux) ? 0 : aux_cnt_r + 1;
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_en_held;
      en_any [*8];
   endsequence
   property p_en_off;
      !en_any |=> regulators_off_o && !five_volt_good_out_o;
   endproperty
   property p_uv_reset;
      (io_rail_uv_i || core_rail_uv_i) |=> !rail_reset_out_n_o;
   endproperty
   property p_uv_good;
      (aux_rail_uv_i || prot_rail_uv_i) |=> !five_volt_good_out_o;
   endproperty
   property p_short_good;
      prot_rail_batt_short_i |=> !five_volt_good_out_o;
   endproperty
   property p_thermal;
      thermal_shutdown_flag_i |=> master_fault_reset_o && regulators_off_o;
   endproperty
   property p_diode_latch;
      catch_diode_missing_i ##1 s_en_held |-> master_fault_reset_o;
   endproperty
   property p_release;
      $rose(rail_reset_out_n_o) |-> ok_cnt_r >= RESET_DELAY_CYC;
   endproperty
   property p_io_ov;
      (ov_cnt_r == OV_DELAY_CYC) && ov_io
         |-> ##[1:3] (!rail_reset_out_n_o && regulators_off_o);
   endproperty
   property p_aux_ov;
      (aux_cnt_r == OV_DELAY_CYC) && ov_aux |-> ##[1:3] !five_volt_good_out_o;
   endproperty
   property p_pre_ov;
      pre_regulator_output_ov_i |=> !pre_switch_enable_o;
   endproperty
   property p_pulse_end;
      core_hs_over_limit_i |=> core_pulse_end_o;
   endproperty
   a_en_off: assert property (p_en_off)
      else $error("regulators not off while disabled");
   a_uv_reset: assert property (p_uv_reset)
      else $error("reset not low on io or core undervoltage");
   a_uv_good: assert property (p_uv_good)
      else $error("good not low on aux or protected undervoltage");
   a_short_good: assert property (p_short_good)
      else $error("good not low on battery short");
   a_thermal: assert property (p_thermal)
      else $error("no master fault on thermal shutdown");
   a_diode_latch: assert property (p_diode_latch)
      else $error("missing diode fault not held");
   a_release: assert property (p_release)
      else $error("reset released too early");
   a_io_ov: assert property (p_io_ov)
      else $error("io or core overvoltage not acted on");
   a_aux_ov: assert property (p_aux_ov)
      else $error("aux overvoltage did not drop good");
   a_pre_ov: assert property (p_pre_ov)
      else $error("pre-regulator kept switching on overvoltage");
   a_pulse_end: assert property (p_pulse_end)
      else $error("core pulse not ended on current limit");
endmodule

bind rfs_supervisor rfs_supervisor_monitor #(
   .RESET_DELAY_CYC(RESET_DELAY_CYC),
   .OV_DELAY_CYC   (OV_DELAY_CYC)
) u_rfs_supervisor_monitor (.*);

// ### dv/rfs_supervisor_tb_top.sv
// Self-checking bench for the regulator fault supervisor.
// Assumes delays shortened to 20 and 10 cycles of a 250 MHz clock.
module rfs_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned RLS = 20;
   localparam int unsigned OVD = 10;
   logic clk_sys_i, rst_i = 1'h1, logic_enable_input_i = 1'h0,
      battery_enable_one_i = 1'h0, battery_enable_two_i = 1'h0,
      io_rail_uv_i = 1'h0, core_rail_uv_i = 1'h0, aux_rail_uv_i = 1'h0,
      prot_rail_uv_i = 1'h0, io_rail_ov_i = 1'h0, core_rail_ov_i = 1'h0,
      aux_rail_ov_i = 1'h0, prot_rail_ov_i = 1'h0,
      prot_rail_batt_short_i = 1'h0, core_feedback_short_i = 1'h0,
      core_hs_over_limit_i = 1'h0, core_oc_event_i = 1'h0,
      core_below_low_i = 1'h0, pre_oc_event_i = 1'h0, pre_below_low_i = 1'h0,
      pre_regulator_output_ov_i = 1'h0, pre_regulator_output_open_i = 1'h0,
      reg_wr_i = 1'h0, reg_rd_i = 1'h0;
   logic thermal_shutdown_flag_i, bias_uv_i, pump_rail_uv_i, pump_rail_ov_i,
      ref_gap_uv_i, fault_gap_uv_i, freq_pin_fault_i, slew_pin_fault_i,
      catch_diode_missing_i, pre_regulator_current_limit_i;
   logic [9:0] flt = 10'h000;
   logic [rfs_pkg::ADDR_W-1:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd;
   logic rail_reset_out_n_o, five_volt_good_out_o, master_fault_reset_o,
      regulators_off_o, pre_switch_enable_o, pre_max_duty_o,
      core_switch_enable_o, core_pulse_end_o, core_hiccup_o, pre_hiccup_o,
      reset_pin, good_pin;
   int err_total = 0, comparisons = 0;
   int unsigned releases;
   // Low four bits line up with the latch bits of STATUS
   assign {freq_pin_fault_i, fault_gap_uv_i, ref_gap_uv_i, pump_rail_uv_i,
      bias_uv_i, thermal_shutdown_flag_i, pre_regulator_current_limit_i,
      catch_diode_missing_i, pump_rail_ov_i, slew_pin_fault_i} = flt;
   rfs_supervisor #(.RESET_DELAY_CYC(RLS), .OV_DELAY_CYC(OVD)) u_rfs_supervisor (
      .clk_sys_i, .rst_i, .logic_enable_input_i, .battery_enable_one_i,
      .battery_enable_two_i, .io_rail_uv_i, .core_rail_uv_i, .aux_rail_uv_i,
      .prot_rail_uv_i, .io_rail_ov_i, .core_rail_ov_i, .aux_rail_ov_i,
      .prot_rail_ov_i, .prot_rail_batt_short_i, .thermal_shutdown_flag_i,
      .bias_uv_i, .pump_rail_uv_i, .pump_rail_ov_i, .ref_gap_uv_i,
      .fault_gap_uv_i, .freq_pin_fault_i, .slew_pin_fault_i,
      .catch_diode_missing_i, .pre_regulator_current_limit_i,
      .core_feedback_short_i, .core_hs_over_limit_i, .core_oc_event_i,
      .core_below_low_i, .pre_oc_event_i, .pre_below_low_i,
      .pre_regulator_output_ov_i, .pre_regulator_output_open_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rail_reset_out_n_o,
      .five_volt_good_out_o, .master_fault_reset_o, .regulators_off_o,
      .pre_switch_enable_o, .pre_max_duty_o, .core_switch_enable_o,
      .core_pulse_end_o, .core_hiccup_o, .pre_hiccup_o);
   rfs_host_model u_rfs_host_model (.clk_sys_i,
      .reset_drv_n_i(rail_reset_out_n_o), .good_drv_i(five_volt_good_out_o),
      .reset_pin_n_o(reset_pin), .good_pin_o(good_pin), .releases_o(releases));
   initial begin
      clk_sys_i = 1'h0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t word %h want %h", $time, got, exp);
      end
   endtask
   task reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'h1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'h0;
   endtask
   task reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'h1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'h0;
      #1;
      d = reg_rdata_o;
   endtask
   task en_cycle;
      @(posedge clk_sys_i);
      battery_enable_two_i <= 1'h0;
      @(posedge clk_sys_i);
      battery_enable_two_i <= 1'h1;
      tick(3);
   endtask
   task t_enables;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         {logic_enable_input_i, battery_enable_one_i, battery_enable_two_i}
            <= (i == 3) ? 3'h0 : 3'h1 << i;
         tick(2);
         chk1(regulators_off_o, i == 3);
      end
   endtask
   task t_release;
      @(posedge clk_sys_i);
      battery_enable_two_i <= 1'h1;
      io_rail_uv_i <= 1'h1;
      tick(5);
      chk1(reset_pin, 1'h0);
      @(posedge clk_sys_i);
      io_rail_uv_i <= 1'h0;
      tick(RLS - 2);
      chk1(reset_pin, 1'h0);
      tick(5);
      chk1(reset_pin, 1'h1);
      chk32(releases, 32'h1);
      chk1(good_pin, 1'h1);
      @(posedge clk_sys_i);
      aux_rail_uv_i <= 1'h1;
      tick(2);
      chk1(good_pin, 1'h0);
      chk1(reset_pin, 1'h1);
      reg_read(rfs_pkg::REG_STATUS, rd);
      chk1(rd[rfs_pkg::ST_LDO_UV], 1'h1);
      @(posedge clk_sys_i);
      aux_rail_uv_i <= 1'h0;
      core_rail_uv_i <= 1'h1;
      tick(2);
      chk1(good_pin, 1'h1);
      chk1(reset_pin, 1'h0);
      @(posedge clk_sys_i);
      core_rail_uv_i <= 1'h0;
      tick(RLS + 3);
   endtask
   task t_ov;
      // Two bursts just short of the delay must not qualify
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys_i);
         aux_rail_ov_i <= 1'h1;
         repeat (i == 2 ? OVD + 3 : OVD - 2) @(posedge clk_sys_i);
         aux_rail_ov_i <= i == 2;
         tick(1);
         chk1(good_pin, i != 2);
      end
      chk1(reset_pin, 1'h1);
      @(posedge clk_sys_i);
      aux_rail_ov_i <= 1'h0;
      prot_rail_batt_short_i <= 1'h1;
      tick(2);
      chk1(good_pin, 1'h0);
      chk1(reset_pin, 1'h1);
      tick(OVD + 2);
      chk1(reset_pin, 1'h0);
      @(posedge clk_sys_i);
      prot_rail_batt_short_i <= 1'h0;
      tick(2);
      chk1(regulators_off_o, 1'h0);
      @(posedge clk_sys_i);
      core_rail_ov_i <= 1'h1;
      repeat (OVD + 3) @(posedge clk_sys_i);
      core_rail_ov_i <= 1'h0;
      tick(OVD);
      chk1(regulators_off_o, 1'h1);
      chk1(good_pin, 1'h0);
      en_cycle;
      chk1(regulators_off_o, 1'h0);
      tick(RLS + 3);
   endtask
   task t_master;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys_i);
         flt <= 10'h001 << i;
         @(posedge clk_sys_i);
         flt <= 10'h000;
         #1;
         chk1(master_fault_reset_o, 1'h1);
         tick(6);
         chk1(master_fault_reset_o, i < 4);
         reg_read(rfs_pkg::REG_STATUS, rd);
         chk32({27'h0, rd[4:0]}, i < 4 ? 32'h1 << i : 32'h0);
         en_cycle;
         chk1(master_fault_reset_o, 1'h0);
      end
   endtask
   task oc_pulse(input logic p);
      @(posedge clk_sys_i);
      core_oc_event_i <= !p;
      pre_oc_event_i <= p;
      @(posedge clk_sys_i);
      core_oc_event_i <= 1'h0;
      pre_oc_event_i <= 1'h0;
      tick(2);
   endtask
   task t_hiccup;
      @(posedge clk_sys_i);
      core_below_low_i <= 1'h1;
      repeat (29) oc_pulse(1'h0);
      chk1(core_hiccup_o, 1'h0);
      oc_pulse(1'h0);
      chk1(core_hiccup_o, 1'h1);
      repeat (119) oc_pulse(1'h1);
      chk1(pre_hiccup_o, 1'h0);
      repeat (3) oc_pulse(1'h1);
      chk1(pre_hiccup_o, 1'h1);
      reg_read(rfs_pkg::REG_OC_COUNT, rd);
      chk32(rd, 32'h0000_781e);
      en_cycle;
      chk1(core_hiccup_o | pre_hiccup_o, 1'h0);
   endtask
   task t_misc;
      reg_write(rfs_pkg::REG_CTRL, 32'h1);
      reg_read(rfs_pkg::REG_CTRL, rd);
      chk32(rd, 32'h1);
      chk1(reset_pin, 1'h0);
      reg_write(rfs_pkg::REG_CTRL, 32'h0);
      reg_read(4'hc, rd);
      chk32(rd, 32'h0);
      @(posedge clk_sys_i);
      {pre_regulator_output_ov_i, pre_regulator_output_open_i,
         core_feedback_short_i, core_hs_over_limit_i} <= 4'hf;
      tick(2);
      chk1(pre_switch_enable_o, 1'h0);
      chk1(pre_max_duty_o, 1'h1);
      chk1(good_pin, 1'h1);
      chk1(core_switch_enable_o, 1'h1);
      chk1(core_pulse_end_o, 1'h1);
      chk1(reset_pin, 1'h0);
      @(posedge clk_sys_i);
      pre_regulator_output_ov_i <= 1'h0;
      tick(2);
      chk1(pre_switch_enable_o, 1'h1);
   endtask
   task print_verdict;
      if (err_total == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      tick(1);
      chk1(regulators_off_o, 1'h1);
      t_enables;
      t_release;
      t_ov;
      t_master;
      t_hiccup;
      t_misc;
      print_verdict;
   end
   initial begin
      repeat (6000) @(posedge clk_sys_i);
      err_total++;
      print_verdict;
   end
endmodule

// ### rtl/rfs_pkg.sv
// Constants shared by the regulator fault supervisor and its timers.
// Assumes a single 250 MHz system clock.
package rfs_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
   localparam int unsigned RESET_DELAY_US  = 15_000;
   localparam int unsigned OV_DELAY_US     = 8_000;
   localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_US * CYC_PER_US;
   localparam int unsigned OV_DELAY_CYC    = OV_DELAY_US * CYC_PER_US;

   localparam int unsigned OC_CNT_W        = 7;
   localparam logic [6:0]  HICCUP_LOW_CNT  = 7'h1e;
   localparam logic [6:0]  HICCUP_HIGH_CNT = 7'h78;

   // Register port
   localparam int unsigned ADDR_W          = 4;
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_STATUS      = 4'h4;
   localparam logic [3:0]  REG_OC_COUNT    = 4'h8;
   localparam int unsigned CTRL_HOLD_BIT   = 0;
   localparam int unsigned OC_PRE_LSB      = 8;

   // Latched fault bits
   localparam int unsigned LATCH_W         = 5;
   localparam int unsigned LAT_SLEW        = 0;
   localparam int unsigned LAT_PUMP_OV     = 1;
   localparam int unsigned LAT_DIODE       = 2;
   localparam int unsigned LAT_PRE_ILIM    = 3;
   localparam int unsigned LAT_RAIL_OV     = 4;

   // Status bits above the latched faults
   localparam int unsigned ST_RESET_N      = 8;
   localparam int unsigned ST_GOOD         = 9;
   localparam int unsigned ST_MFR          = 10;
   localparam int unsigned ST_REGS_OFF     = 11;
   localparam int unsigned ST_CORE_HIC     = 12;
   localparam int unsigned ST_PRE_HIC      = 13;
   localparam int unsigned ST_LDO_UV       = 14;
   localparam int unsigned ST_ENABLE       = 15;

   // Timer slots
   localparam int unsigned N_TMR           = 4;
   localparam int unsigned TMR_RELEASE     = 0;
   localparam int unsigned TMR_SHORT       = 1;
   localparam int unsigned TMR_RAIL_OV     = 2;
   localparam int unsigned TMR_AUX_OV      = 3;
endpackage

// ### rtl/rfs_qual_timer.sv
// Qualification timer: expired while cond has held CYCLES cycles.
// Assumes cond is synchronous to clk_sys_i.
module rfs_qual_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   rfs_tmr_if.timer  tmr
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LIMIT = W'(CYCLES);

   typedef struct packed {
      logic [W-1:0] cnt;
   } rfs_tmr_state_t;

   rfs_tmr_state_t s_r;
   rfs_tmr_state_t s_nxt;

   if (CYCLES < 1) begin : g_bad
      $error("rfs_qual_timer: CYCLES must be at least 1");
   end

   always_comb begin
      s_nxt = s_r;
      // Any drop restarts the wait
      if (!tmr.cond) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt != LIMIT) begin
         s_nxt.cnt = s_r.cnt + W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Gated by cond so the drop is seen with no delay
   assign tmr.expired = tmr.cond && (s_r.cnt == LIMIT);
endmodule

// ### rtl/rfs_supervisor.sv
// Regulator fault supervisor: combines rail flags into reset, five-volt
// good, master fault reset and regulator shutdown, with hiccup counting.
// Assumes all flag inputs are synchronous to clk_sys_i; rst_i is the
// internal power-on reset. Event inputs are one-cycle pulses.
//
// Design decisions made here: the address-and-strobe port and the register offsets.

module rfs_supervisor #(
   parameter int unsigned RESET_DELAY_CYC = rfs_pkg::RESET_DELAY_CYC,
   parameter int unsigned OV_DELAY_CYC    = rfs_pkg::OV_DELAY_CYC
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_i,
   input  wire logic                      logic_enable_input_i,
   input  wire logic                      battery_enable_one_i,
   input  wire logic                      battery_enable_two_i,
   input  wire logic                      io_rail_uv_i,
   input  wire logic                      core_rail_uv_i,
   input  wire logic                      aux_rail_uv_i,
   input  wire logic                      prot_rail_uv_i,
   input  wire logic                      io_rail_ov_i,
   input  wire logic                      core_rail_ov_i,
   input  wire logic                      aux_rail_ov_i,
   input  wire logic                      prot_rail_ov_i,
   input  wire logic                      prot_rail_batt_short_i,
   input  wire logic                      thermal_shutdown_flag_i,
   input  wire logic                      bias_uv_i,
   input  wire logic                      pump_rail_uv_i,
   input  wire logic                      pump_rail_ov_i,
   input  wire logic                      ref_gap_uv_i,
   input  wire logic                      fault_gap_uv_i,
   input  wire logic                      freq_pin_fault_i,
   input  wire logic                      slew_pin_fault_i,
   input  wire logic                      catch_diode_missing_i,
   input  wire logic                      pre_regulator_current_limit_i,
   input  wire logic                      core_feedback_short_i,
   input  wire logic                      core_hs_over_limit_i,
   input  wire logic                      core_oc_event_i,
   input  wire logic                      core_below_low_i,
   input  wire logic                      pre_oc_event_i,
   input  wire logic                      pre_below_low_i,
   input  wire logic                      pre_regulator_output_ov_i,
   input  wire logic                      pre_regulator_output_open_i,
   input  wire logic [rfs_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]               reg_wdata_i,
   input  wire logic                      reg_wr_i,
   input  wire logic                      reg_rd_i,
   output logic      [31:0]               reg_rdata_o,
   output logic                           rail_reset_out_n_o,
   output logic                           five_volt_good_out_o,
   output logic                           master_fault_reset_o,
   output logic                           regulators_off_o,
   output logic                           pre_switch_enable_o,
   output logic                           pre_max_duty_o,
   output logic                           core_switch_enable_o,
   output logic                           core_pulse_end_o,
   output logic                           core_hiccup_o,
   output logic                           pre_hiccup_o
);
   typedef struct packed {
      logic                           force_hold;
      logic [rfs_pkg::LATCH_W-1:0]    latch;
      logic [rfs_pkg::OC_CNT_W-1:0]   core_cnt;
      logic [rfs_pkg::OC_CNT_W-1:0]   pre_cnt;
      logic                           core_hic;
      logic                           pre_hic;
      logic                           reset_n;
      logic                           good;
      logic                           mfr;
      logic                           regs_off;
      logic                           pre_sw_en;
      logic                           pre_maxd;
      logic                           core_sw_en;
      logic                           core_end;
      logic [31:0]                    rdata;
   } rfs_state_t;

   rfs_state_t s_r;
   rfs_state_t s_nxt;

   rfs_tmr_if tmr [rfs_pkg::N_TMR] ();
   logic [rfs_pkg::N_TMR-1:0] tmr_cond;
   logic [rfs_pkg::N_TMR-1:0] tmr_exp;

   if (RESET_DELAY_CYC < 1 || OV_DELAY_CYC < 1) begin : g_bad
      $error("rfs_supervisor: delay counts must be at least 1");
   end

   for (genvar g = 0; g < rfs_pkg::N_TMR; g++) begin : g_tmr
      assign tmr[g].cond = tmr_cond[g];
      assign tmr_exp[g]  = tmr[g].expired;
      rfs_qual_timer #(
         .CYCLES (g == rfs_pkg::TMR_RELEASE ? RESET_DELAY_CYC
                                             : OV_DELAY_CYC)
      ) u_tmr (
         .clk_sys_i (clk_sys_i),
         .rst_i     (rst_i),
         .tmr       (tmr[g])
      );
   end

   logic enable;
   logic ldo_uv;
   logic [rfs_pkg::LATCH_W-1:0] latch_set;
   logic mfr_now;
   logic regs_off_now;
   logic short_trip;
   logic [rfs_pkg::OC_CNT_W-1:0] core_lim;
   logic [rfs_pkg::OC_CNT_W-1:0] pre_lim;
   logic [31:0] status_word;

   assign enable = logic_enable_input_i | battery_enable_one_i
                 | battery_enable_two_i;
   assign ldo_uv = io_rail_uv_i | aux_rail_uv_i | prot_rail_uv_i;

   // Overvoltage and short windows
   assign tmr_cond[rfs_pkg::TMR_SHORT]   = prot_rail_batt_short_i;
   assign tmr_cond[rfs_pkg::TMR_RAIL_OV] = io_rail_ov_i | core_rail_ov_i;
   assign tmr_cond[rfs_pkg::TMR_AUX_OV]  = aux_rail_ov_i | prot_rail_ov_i;
   assign short_trip = tmr_exp[rfs_pkg::TMR_SHORT];

   always_comb begin
      latch_set = '0;
      latch_set[rfs_pkg::LAT_SLEW]     = slew_pin_fault_i;
      latch_set[rfs_pkg::LAT_PUMP_OV]  = pump_rail_ov_i;
      latch_set[rfs_pkg::LAT_DIODE]    = catch_diode_missing_i;
      latch_set[rfs_pkg::LAT_PRE_ILIM] =
         pre_regulator_current_limit_i;
      latch_set[rfs_pkg::LAT_RAIL_OV]  =
         tmr_exp[rfs_pkg::TMR_RAIL_OV];
   end

   // Direct terms make the reset act in the detecting cycle
   assign mfr_now = thermal_shutdown_flag_i | bias_uv_i | pump_rail_uv_i
                  | ref_gap_uv_i | fault_gap_uv_i | freq_pin_fault_i
                  | (|latch_set[rfs_pkg::LAT_PRE_ILIM:rfs_pkg::LAT_SLEW])
                  | (|s_r.latch[rfs_pkg::LAT_PRE_ILIM:rfs_pkg::LAT_SLEW]);

   assign regs_off_now = mfr_now | !enable | short_trip
                       | latch_set[rfs_pkg::LAT_RAIL_OV]
                       | s_r.latch[rfs_pkg::LAT_RAIL_OV];

   // Release wait only runs once both rails are above threshold
   assign tmr_cond[rfs_pkg::TMR_RELEASE] = !core_rail_uv_i
                                         && !io_rail_uv_i;

   // Threshold follows the rail level at the event
   assign core_lim = core_below_low_i ? rfs_pkg::HICCUP_LOW_CNT
                                      : rfs_pkg::HICCUP_HIGH_CNT;
   assign pre_lim  = pre_below_low_i ? rfs_pkg::HICCUP_LOW_CNT
                                     : rfs_pkg::HICCUP_HIGH_CNT;

   always_comb begin
      status_word = '0;
      status_word[rfs_pkg::LATCH_W-1:0] = s_r.latch;
      status_word[rfs_pkg::ST_RESET_N]  = s_r.reset_n;
      status_word[rfs_pkg::ST_GOOD]     = s_r.good;
      status_word[rfs_pkg::ST_MFR]      = s_r.mfr;
      status_word[rfs_pkg::ST_REGS_OFF] = s_r.regs_off;
      status_word[rfs_pkg::ST_CORE_HIC] = s_r.core_hic;
      status_word[rfs_pkg::ST_PRE_HIC]  = s_r.pre_hic;
      status_word[rfs_pkg::ST_LDO_UV]   = ldo_uv;
      status_word[rfs_pkg::ST_ENABLE]   = enable;
   end

   always_comb begin
      s_nxt = s_r;

      // Latched faults: set wins over the enable-low clear
      if (!enable) begin
         s_nxt.latch = latch_set;
      end else begin
         s_nxt.latch = s_r.latch | latch_set;
      end

      // Overcurrent counting and hiccup entry
      if (!enable) begin
         s_nxt.core_cnt = '0;
         s_nxt.pre_cnt  = '0;
         s_nxt.core_hic = 1'b0;
         s_nxt.pre_hic  = 1'b0;
      end else begin
         if (core_oc_event_i && !s_r.core_hic) begin
            s_nxt.core_cnt = s_r.core_cnt + 7'h01;
            if (s_r.core_cnt + 7'h01 >= core_lim) begin
               s_nxt.core_hic = 1'b1;
            end
         end
         if (pre_oc_event_i && !s_r.pre_hic) begin
            s_nxt.pre_cnt = s_r.pre_cnt + 7'h01;
            if (s_r.pre_cnt + 7'h01 >= pre_lim) begin
               s_nxt.pre_hic = 1'b1;
            end
         end
      end

      s_nxt.mfr      = mfr_now;
      s_nxt.regs_off = regs_off_now;

      // Reset: undervoltage drops it at once, no latch
      s_nxt.reset_n = tmr_exp[rfs_pkg::TMR_RELEASE]
                    && !regs_off_now
                    && !core_feedback_short_i
                    && !s_r.force_hold;

      // Good output ignores io/core UV
      s_nxt.good = !aux_rail_uv_i && !prot_rail_uv_i
                 && !prot_rail_batt_short_i
                 && !tmr_exp[rfs_pkg::TMR_AUX_OV]
                 && !regs_off_now;

      // Open output keeps switching flat out
      s_nxt.pre_sw_en = !regs_off_now && !pre_regulator_output_ov_i
                      && !s_nxt.pre_hic;
      s_nxt.pre_maxd  = pre_regulator_output_open_i && !regs_off_now;

      // Feedback short does not stop switching
      s_nxt.core_sw_en = !regs_off_now && !s_nxt.core_hic;
      s_nxt.core_end   = core_hs_over_limit_i;

      if (reg_wr_i && reg_addr_i == rfs_pkg::REG_CTRL) begin
         s_nxt.force_hold = reg_wdata_i[rfs_pkg::CTRL_HOLD_BIT];
      end

      // Read data stand for one cycle only
      s_nxt.rdata = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            rfs_pkg::REG_CTRL: begin
               s_nxt.rdata[rfs_pkg::CTRL_HOLD_BIT] = s_r.force_hold;
            end
            rfs_pkg::REG_STATUS: begin
               s_nxt.rdata = status_word;
            end
            rfs_pkg::REG_OC_COUNT: begin
               s_nxt.rdata[rfs_pkg::OC_CNT_W-1:0] = s_r.core_cnt;
               s_nxt.rdata[rfs_pkg::OC_PRE_LSB +: rfs_pkg::OC_CNT_W] =
                  s_r.pre_cnt;
            end
            default: begin
               s_nxt.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         // Power-on reset: everything cleared except master fault reset and regulators off, both set
         s_r          <= '0;
         s_r.mfr      <= 1'b1;
         s_r.regs_off <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_o          = s_r.rdata;
   assign rail_reset_out_n_o   = s_r.reset_n;
   assign five_volt_good_out_o = s_r.good;
   assign master_fault_reset_o = s_r.mfr;
   assign regulators_off_o     = s_r.regs_off;
   assign pre_switch_enable_o  = s_r.pre_sw_en;
   assign pre_max_duty_o       = s_r.pre_maxd;
   assign core_switch_enable_o = s_r.core_sw_en;
   assign core_pulse_end_o     = s_r.core_end;
   assign core_hiccup_o        = s_r.core_hic;
   assign pre_hiccup_o         = s_r.pre_hic;
endmodule

// ### rtl/rfs_tmr_if.sv
// Carrier between the supervisor and one qualification timer.
// Assumes both ends run on the same clock.
interface rfs_tmr_if;
   logic cond;
   logic expired;
   modport ctrl  (output cond, input expired);
   modport timer (input cond, output expired);
endinterface
